// [rdl_ready_lamp.sv]
/*
  rdl_ready_lamp: ready lamp indicator (green, orange = both, red) with apb registers.
  assumes: status inputs arrive asynchronously from link, fault and firmware logic;
  an apb master on pclk; the lamp driver mixes green and red to show orange.
*/
// The implementer's own choices: register access over APB and the address map.
// Overview of operation
// - green steady when link cyclic and ready
// - orange steady while link set-up runs
// - red steady while any fault present and after it until acknowledged
// - green/red flash 0.5 Hz during download
// - green/red 2 Hz after download until power-cycle
// - identification blinks against colour captured at start
// - lamp dark without valid electronics supply
`timescale 1ns/100ps
`default_nettype none

module rdl_ready_lamp #(
  parameter int unsigned TICK_CYCLES = rdl_pkg::TICK_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        supply_ok,
  input  wire logic        link_cyclic,
  input  wire logic        link_setup,
  input  wire logic        fault_present,
  input  wire logic        fw_loading,
  input  wire logic        fw_done,
  output var  logic        lamp_green,
  output var  logic        lamp_red,
  output var  logic        irq
);

  localparam int unsigned IN_W = rdl_pkg::IN_W;
  localparam int unsigned EV_W = rdl_pkg::EV_W;
  localparam int unsigned MS_W = rdl_pkg::MS_W;

  // half-period phase of the shared ms counter
  function automatic logic first_half(input logic [MS_W-1:0] ms,
                                      input int unsigned     half_ms);
    int unsigned q;
    q = (32'(ms) / half_ms);
    return (q % 2) == 0;
  endfunction

  // input synchronisers
  logic [IN_W-1:0]   raw_in;
  logic [IN_W-1:0]   sync1_reg;
  logic [IN_W-1:0]   sync2_reg;
  logic [IN_W-1:0]   sync3_reg;
  logic [IN_W-1:0]   agree;
  rdl_pkg::rdl_in_t  in_reg;
  rdl_pkg::rdl_in_t  in_next;

  // divider
  logic [31:0]       tick_cnt_reg;
  logic [31:0]       tick_cnt_next;
  logic              tick;
  logic [MS_W-1:0]   ms_cnt_reg;
  logic [MS_W-1:0]   ms_cnt_next;
  logic              ph_slow;
  logic              ph_fast;
  logic              ph_ident;

  // condition latches
  logic              fault_lat_reg;
  logic              fault_lat_next;
  logic              fw_done_lat_reg;
  logic              fw_done_lat_next;
  logic              ident_en_reg;
  logic              ident_en_next;
  logic              ident_prev_reg;
  logic              ident_start;
  logic              ident_red_reg;
  logic              ident_red_next;
  logic              ack_pulse;

  // lamp state
  rdl_pkg::rdl_mode_t mode_reg;
  rdl_pkg::rdl_mode_t mode_next;
  rdl_pkg::rdl_lamp_t lamp_reg;
  rdl_pkg::rdl_lamp_t lamp_next;

  // interrupts
  logic [EV_W-1:0]   events;
  logic [EV_W-1:0]   int_stat_reg;
  logic [EV_W-1:0]   int_stat_next;
  logic [EV_W-1:0]   int_mask_reg;
  logic [EV_W-1:0]   int_mask_next;
  logic [EV_W-1:0]   w1c;
  logic              irq_reg;
  logic              irq_next;

  // apb
  logic              apb_setup;
  logic              apb_access;
  logic              apb_wr;
  logic              hit_ctrl;
  logic              hit_status;
  logic              hit_int_stat;
  logic              hit_int_mask;
  logic              addr_ok;
  logic [31:0]       ctrl_word;
  logic [31:0]       status_word;
  logic [31:0]       rdata_mux;
  logic [31:0]       prdata_reg;
  logic [31:0]       prdata_next;
  logic              pready_reg;
  logic              pslverr_reg;
  logic              pslverr_next;

  // a change counts only once stages two and three agree
  assign raw_in  = {supply_ok, link_cyclic, link_setup, fault_present, fw_loading, fw_done};
  assign agree   = ~(sync2_reg ^ sync3_reg);
  assign in_next = rdl_pkg::rdl_in_t'((sync3_reg & agree) | (IN_W'(in_reg) & ~agree));

  // reset reads as supply missing: lamp dark until inputs settle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
      in_reg    <= '0;
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      in_reg    <= in_next;
    end
  end

  // free-running divider, never reset by mode changes so flashes stay in step
  assign tick          = (tick_cnt_reg == 32'(TICK_CYCLES - 1));
  assign tick_cnt_next = tick ? 32'h0 : tick_cnt_reg + 32'h1;
  assign ms_cnt_next   = !tick ? ms_cnt_reg :
                         (ms_cnt_reg == MS_W'(rdl_pkg::FRAME_MS - 1)) ? '0 :
                         ms_cnt_reg + MS_W'(1);

  // one counter for all rates, so phases never drift apart
  assign ph_slow  = first_half(ms_cnt_reg, rdl_pkg::SLOW_HALF_MS);
  assign ph_fast  = first_half(ms_cnt_reg, rdl_pkg::FAST_HALF_MS);
  assign ph_ident = first_half(ms_cnt_reg, rdl_pkg::IDENT_HALF_MS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_reg <= 32'h0;
      ms_cnt_reg   <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      ms_cnt_reg   <= ms_cnt_next;
    end
  end

  // fault raw input has no message-type filtering, so reconfiguration cannot hide it
  assign ack_pulse      = apb_wr & hit_ctrl & pwdata[rdl_pkg::CTRL_ACK_BIT];
  assign fault_lat_next = in_reg.fault_present |
                          (fault_lat_reg & ~ack_pulse);

  // only a power-on reset leaves the download-complete indication
  assign fw_done_lat_next = fw_done_lat_reg | in_reg.fw_done;

  assign ident_en_next  = (apb_wr & hit_ctrl) ? pwdata[rdl_pkg::CTRL_IDENT_BIT]
                                              : ident_en_reg;
  // base colour taken before ident mode reaches the lamp
  assign ident_start    = ident_en_reg & ~ident_prev_reg;
  assign ident_red_next = ident_start ? lamp_reg.red & ~lamp_reg.green
                                      : ident_red_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_lat_reg   <= 1'b0;
      fw_done_lat_reg <= 1'b0;
      ident_en_reg    <= rdl_pkg::CTRL_IDENT_RST;
      ident_prev_reg  <= 1'b0;
      ident_red_reg   <= 1'b0;
    end else begin
      fault_lat_reg   <= fault_lat_next;
      fw_done_lat_reg <= fw_done_lat_next;
      ident_en_reg    <= ident_en_next;
      ident_prev_reg  <= ident_en_reg;
      ident_red_reg   <= ident_red_next;
    end
  end

  // lamp mode by priority
  // supply first: nothing may light a lamp without supply
  always_comb begin
    if (!in_reg.supply_ok) begin
      mode_next = rdl_pkg::MODE_OFF;
    end else if (ident_en_reg) begin
      mode_next = rdl_pkg::MODE_IDENT;
    end else if (fw_done_lat_reg) begin
      mode_next = rdl_pkg::MODE_FW_DONE;
    end else if (in_reg.fw_loading) begin
      mode_next = rdl_pkg::MODE_FW_LOAD;
    end else if (fault_lat_reg) begin
      mode_next = rdl_pkg::MODE_RED;
    end else if (in_reg.link_cyclic) begin
      mode_next = rdl_pkg::MODE_GREEN;
    end else if (in_reg.link_setup) begin
      mode_next = rdl_pkg::MODE_ORANGE;
    end else begin
      mode_next = rdl_pkg::MODE_OFF;
    end
  end

  // colour from mode; orange is both emitters lit
  always_comb begin
    unique case (mode_reg)
      rdl_pkg::MODE_OFF: begin
        lamp_next = '{green: 1'b0, red: 1'b0};
      end
      rdl_pkg::MODE_GREEN: begin
        lamp_next = '{green: 1'b1, red: 1'b0};
      end
      rdl_pkg::MODE_ORANGE: begin
        lamp_next = '{green: 1'b1, red: 1'b1};
      end
      rdl_pkg::MODE_RED: begin
        lamp_next = '{green: 1'b0, red: 1'b1};
      end
      rdl_pkg::MODE_FW_LOAD: begin
        lamp_next = '{green: ph_slow, red: ~ph_slow};
      end
      rdl_pkg::MODE_FW_DONE: begin
        lamp_next = '{green: ph_fast, red: ~ph_fast};
      end
      rdl_pkg::MODE_IDENT: begin
        lamp_next = '{green: ph_ident | ~ident_red_reg,
                      red:   ph_ident | ident_red_reg};
      end
      default: begin
        lamp_next = '{green: 1'b0, red: 1'b0};
      end
    endcase
  end

  // one cycle of lag from mode to lamp, invisible at flash rates
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= rdl_pkg::MODE_OFF;
      lamp_reg <= '0;
    end else begin
      mode_reg <= mode_next;
      lamp_reg <= lamp_next;
    end
  end

  assign lamp_green = lamp_reg.green;
  assign lamp_red   = lamp_reg.red;

  // sticky events; a new event beats a clear in the same cycle
  assign events[rdl_pkg::EV_FAULT]       = fault_lat_next & ~fault_lat_reg;
  assign events[rdl_pkg::EV_FWDONE]      = fw_done_lat_next & ~fw_done_lat_reg;
  assign events[rdl_pkg::EV_CYCLIC]      = in_next.link_cyclic & ~in_reg.link_cyclic;
  assign events[rdl_pkg::EV_SUPPLY_LOST] = ~in_next.supply_ok & in_reg.supply_ok;

  // write one to clear; zeros leave pending flags alone
  assign w1c           = (apb_wr & hit_int_stat) ? pwdata[EV_W-1:0] : '0;
  assign int_stat_next = events | (int_stat_reg & ~w1c);
  assign int_mask_next = (apb_wr & hit_int_mask) ? pwdata[EV_W-1:0] : int_mask_reg;
  // flags of this edge, so irq carries no extra cycle of lag
  assign irq_next      = |(int_stat_next & int_mask_next);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat_reg <= '0;
      int_mask_reg <= rdl_pkg::INT_MASK_RST;
      irq_reg      <= 1'b0;
    end else begin
      int_stat_reg <= int_stat_next;
      int_mask_reg <= int_mask_next;
      irq_reg      <= irq_next;
    end
  end

  assign irq = irq_reg;

  // apb slave: pready rises in the first access cycle, no wait states
  assign apb_setup    = psel & ~penable;
  assign apb_access   = psel & penable & pready_reg;
  assign apb_wr       = apb_access & pwrite & ~pslverr_reg;
  assign hit_ctrl     = (paddr == rdl_pkg::OFS_CTRL);
  assign hit_status   = (paddr == rdl_pkg::OFS_STATUS);
  assign hit_int_stat = (paddr == rdl_pkg::OFS_INT_STAT);
  assign hit_int_mask = (paddr == rdl_pkg::OFS_INT_MASK);
  assign addr_ok      = hit_ctrl | hit_status | hit_int_stat | hit_int_mask;

  // acknowledge bit is a strobe and reads back as zero
  assign ctrl_word = {31'h0, ident_en_reg};

  // live lamp bits, so software sees the flash phase
  assign status_word = {18'h0,
                        lamp_reg.red,
                        lamp_reg.green,
                        ident_red_reg,
                        in_reg.supply_ok,
                        fw_done_lat_reg,
                        fault_lat_reg,
                        1'b0,
                        mode_reg};

  assign rdata_mux = hit_ctrl     ? ctrl_word :
                     hit_status   ? status_word :
                     hit_int_stat ? {28'h0, int_stat_reg} :
                     hit_int_mask ? {28'h0, int_mask_reg} :
                     32'h0;

  // read data sampled at setup; a flag set meanwhile shows on the next read
  assign prdata_next  = (apb_setup & ~pwrite) ? rdata_mux :
                        apb_setup ? 32'h0 : prdata_reg;
  // error flag ends with its access, never carried into the next
  assign pslverr_next = apb_setup ? ~addr_ok : (pslverr_reg & ~apb_access);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= apb_setup;
      prdata_reg  <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign pready  = pready_reg;
  assign prdata  = prdata_reg;
  assign pslverr = pslverr_reg;

endmodule // rdl_ready_lamp

`default_nettype wire

// [rdl_pkg.sv]
/*
  rdl_pkg: constants, register map and carrier types of the ready lamp indicator.
  assumes: used by the lamp top module alone, the checker and bench hold their own values; pclk at 250 MHz.
*/
`default_nettype none

package rdl_pkg;

  // clock and flash timing, times in ms
  localparam int unsigned CLK_KHZ        = 250000;
  localparam int unsigned TICK_MS        = 1;
  localparam int unsigned TICK_CYCLES    = TICK_MS * CLK_KHZ;
  localparam int unsigned SLOW_HALF_MS   = 1000;  // 0.5 Hz flash
  localparam int unsigned FAST_HALF_MS   = 250;   // 2 Hz flash
  localparam int unsigned IDENT_HALF_MS  = 500;   // 1 Hz identification blink
  localparam int unsigned FRAME_MS       = 2000;  // common multiple of all halves
  localparam int unsigned MS_W           = 11;

  // register map, byte addresses
  localparam logic [7:0] OFS_CTRL        = 8'h00;
  localparam logic [7:0] OFS_STATUS      = 8'h04;
  localparam logic [7:0] OFS_INT_STAT    = 8'h08;
  localparam logic [7:0] OFS_INT_MASK    = 8'h0C;

  // control fields
  localparam int unsigned CTRL_IDENT_BIT = 0;
  localparam int unsigned CTRL_ACK_BIT   = 1;

  // status fields
  localparam int unsigned ST_MODE_LSB    = 0;
  localparam int unsigned ST_FAULT_BIT   = 8;
  localparam int unsigned ST_FWDONE_BIT  = 9;
  localparam int unsigned ST_SUPPLY_BIT  = 10;
  localparam int unsigned ST_IDRED_BIT   = 11;
  localparam int unsigned ST_GREEN_BIT   = 12;
  localparam int unsigned ST_RED_BIT     = 13;

  // interrupt events
  localparam int unsigned EV_W           = 4;
  localparam int unsigned EV_FAULT       = 0;
  localparam int unsigned EV_FWDONE      = 1;
  localparam int unsigned EV_CYCLIC      = 2;
  localparam int unsigned EV_SUPPLY_LOST = 3;

  // reset values
  localparam logic        CTRL_IDENT_RST = 1'b0;
  localparam logic [3:0]  INT_MASK_RST   = 4'h0;

  // synchronised inputs
  typedef struct packed {
    logic supply_ok;
    logic link_cyclic;
    logic link_setup;
    logic fault_present;
    logic fw_loading;
    logic fw_done;
  } rdl_in_t;

  localparam int unsigned IN_W = 6;

  typedef struct packed {
    logic green;
    logic red;
  } rdl_lamp_t;

  typedef enum logic [6:0] {
    MODE_OFF     = 7'h01,
    MODE_GREEN   = 7'h02,
    MODE_ORANGE  = 7'h04,
    MODE_RED     = 7'h08,
    MODE_FW_LOAD = 7'h10,
    MODE_FW_DONE = 7'h20,
    MODE_IDENT   = 7'h40
  } rdl_mode_t;

endpackage

`default_nettype wire

// [rdl_ready_lamp_sva.sv]
/*
  rdl_ready_lamp_sva: port checker of the ready lamp.
  assumes: bound to rdl_ready_lamp, one clock domain.
*/
`timescale 1ns/100ps
`default_nettype none

module rdl_ready_lamp_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        supply_ok,
  input wire logic        fault_present,
  input wire logic        fw_loading,
  input wire logic        fw_done,
  input wire logic        lamp_green,
  input wire logic        lamp_red,
  input wire logic        irq
);
  logic ident_reg;
  logic done_reg;
  logic ctrl_wr;
  // snooped copies, so the checker knows which indication has priority
  assign ctrl_wr = psel && penable && pready && pwrite && (paddr == 8'h00);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ident_reg <= 1'b0;
      done_reg  <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        ident_reg <= pwdata[0];
      end
      if (fw_done) begin
        done_reg <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_dark; (!supply_ok)[*8] |=> !lamp_green && !lamp_red; endproperty
  a_dark: assert property (p_dark) else $error("lamp lit without supply");
  property p_rst; $rose(presetn) |-> !lamp_green && !lamp_red && !irq; endproperty
  a_rst: assert property (p_rst) else $error("outputs active after reset");
  property p_red;
    (fault_present && supply_ok && !fw_loading && !done_reg && !ident_reg)[*8]
      |=> lamp_red && !lamp_green;
  endproperty
  a_red: assert property (p_red) else $error("fault not shown red");
  property p_done; (done_reg && supply_ok)[*8] |=> lamp_green || lamp_red; endproperty
  a_done: assert property (p_done) else $error("lamp dark after download");
  property p_ident; (ident_reg && supply_ok)[*8] |=> lamp_green || lamp_red; endproperty
  a_ident: assert property (p_ident) else $error("lamp dark in identify");
  property p_setup; psel && !penable |=> pready; endproperty
  a_setup: assert property (p_setup) else $error("no answer to access");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("pready longer than one cycle");
  property p_err; pslverr |-> pready && psel && penable; endproperty
  a_err: assert property (p_err) else $error("stray error response");
  property p_wdata; pready && pwrite |-> prdata == 32'h0; endproperty
  a_wdata: assert property (p_wdata) else $error("read data on a write");
endmodule // rdl_ready_lamp_sva

bind rdl_ready_lamp rdl_ready_lamp_sva u_rdl_ready_lamp_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .supply_ok(supply_ok), .fault_present(fault_present), .fw_loading(fw_loading),
  .fw_done(fw_done), .lamp_green(lamp_green), .lamp_red(lamp_red), .irq(irq)
);

`default_nettype wire

// [rdl_link_partner.sv]
/*
  rdl_link_partner: control unit across the serial link, set-up then cyclic.
  assumes: link_go held while the link should run; setup_len sets set-up time.
*/
`timescale 1ns/100ps
`default_nettype none

module rdl_link_partner (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       link_go,
  input  wire logic [7:0] setup_len,
  output wire logic       link_setup,
  output wire logic       link_cyclic
);
  logic [7:0] cnt_reg;
  // saturating, so cyclic traffic never falls back to set-up by itself
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 8'h00;
    end else if (!link_go) begin
      cnt_reg <= 8'h00;
    end else if (cnt_reg != 8'hFF) begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
  assign link_setup  = link_go && (cnt_reg < setup_len);
  assign link_cyclic = link_go && (cnt_reg >= setup_len);
endmodule // rdl_link_partner

`default_nettype wire

// [rdl_ready_lamp_tb.sv]
/*
  rdl_ready_lamp_tb: self-checking bench of the ready lamp.
  assumes: short tick of 4 cycles; partner model drives the link state.
*/
`timescale 1ns/100ps
`default_nettype none

module rdl_ready_lamp_tb;
  typedef struct packed {logic lamp; logic [31:0] data; logic err;} rdl_exp_t;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        supply_ok = 1'b0;
  logic        fault_present = 1'b0;
  logic        fw_loading = 1'b0;
  logic        fw_done = 1'b0;
  logic        link_go = 1'b0;
  logic [7:0]  setup_len = 8'h64;
  logic        link_setup;
  logic        link_cyclic;
  logic        lamp_green;
  logic        lamp_red;
  logic        irq;
  logic        probe = 1'b0;
  rdl_exp_t    exp_q[$];
  rdl_exp_t    e;
  logic [31:0] got;
  logic        gerr;
  int          num_errors = 0;
  int          check_count = 0;
  int          seed;
  logic [31:0] rnd;

  always #2 pclk = ~pclk;

  rdl_ready_lamp #(.TICK_CYCLES(4)) u_rdl_ready_lamp (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .supply_ok(supply_ok), .link_cyclic(link_cyclic), .link_setup(link_setup),
    .fault_present(fault_present), .fw_loading(fw_loading), .fw_done(fw_done),
    .lamp_green(lamp_green), .lamp_red(lamp_red), .irq(irq)
  );
  rdl_link_partner u_rdl_link_partner (
    .pclk(pclk), .presetn(presetn), .link_go(link_go), .setup_len(setup_len),
    .link_setup(link_setup), .link_cyclic(link_cyclic)
  );

  task automatic final_report;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] x, input logic xe);
    if (!wr) begin
      exp_q.push_back('{1'b0, x, xe});
    end
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic look(input logic [2:0] x);
    exp_q.push_back('{1'b1, {29'h0, x}, 1'b0});
    @(posedge pclk);
    probe <= 1'b1;
    @(posedge pclk);
    probe <= 1'b0;
  endtask

  task automatic wait_lamp(input logic [1:0] v, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while ({lamp_green, lamp_red} !== v && n < lim);
    if ({lamp_green, lamp_red} !== v) begin
      num_errors++;
      $display("wrong value lamp wait expected %b seen %b", v, {lamp_green, lamp_red});
    end
  endtask

  // phase b must last half cycles, then a follows
  task automatic flash(input logic [1:0] a, input logic [1:0] b, input int half);
    wait_lamp(a, 3 * half);
    wait_lamp(b, 3 * half);
    repeat (half - 8) @(posedge pclk);
    look({b, 1'b0});
    repeat (8) @(posedge pclk);
    look({a, 1'b0});
  endtask

  always @(posedge pclk) begin
    if ((psel && penable && pready && !pwrite) || probe) begin
      e = exp_q.pop_front();
      got = probe ? {29'h0, lamp_green, lamp_red, irq} : prdata;
      gerr = probe ? 1'b0 : pslverr;
      check_count++;
      if (got !== e.data || gerr !== e.err) begin
        num_errors++;
        $display("wrong value %s expected %h/%b seen %h/%b", e.lamp ? "lamp" : "read",
                 e.data, e.err, got, gerr);
      end
    end
  end

  initial begin
    repeat (90000) @(posedge pclk);
    num_errors++;
    final_report;
  end

  initial begin
    seed = 32'h568C;
    rnd = $random(seed);
    setup_len = 8'h64 + {2'b00, rnd[5:0]};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0, 32'h0, 1'b0);
    apb(1'b0, 8'h0C, 32'h0, 32'h0, 1'b0);
    apb(1'b0, 8'h20, 32'h0, 32'h0, 1'b1);
    apb(1'b1, 8'h0C, rnd, 32'h0, 1'b0);
    apb(1'b0, 8'h0C, 32'h0, rnd & 32'hF, 1'b0);
    apb(1'b1, 8'h0C, 32'h0, 32'h0, 1'b0);
    look(3'b000);
    supply_ok <= 1'b1;
    link_go <= 1'b1;
    repeat (30) @(posedge pclk);
    look(3'b110);
    repeat (200) @(posedge pclk);
    look(3'b100);
    apb(1'b0, 8'h08, 32'h0, 32'h4, 1'b0);
    apb(1'b1, 8'h0C, 32'h4, 32'h0, 1'b0);
    look(3'b101);
    apb(1'b1, 8'h08, 32'h4, 32'h0, 1'b0);
    apb(1'b0, 8'h08, 32'h0, 32'h0, 1'b0);
    apb(1'b1, 8'h0C, 32'h0, 32'h0, 1'b0);
    look(3'b100);
    apb(1'b1, 8'h00, 32'h1, 32'h0, 1'b0);
    flash(2'b11, 2'b10, 2000);
    apb(1'b1, 8'h00, 32'h0, 32'h0, 1'b0);
    fault_present <= 1'b1;
    repeat (10) @(posedge pclk);
    apb(1'b1, 8'h00, 32'h2, 32'h0, 1'b0);
    repeat (4) @(posedge pclk);
    look(3'b010);
    apb(1'b1, 8'h00, 32'h1, 32'h0, 1'b0);
    flash(2'b11, 2'b01, 2000);
    apb(1'b1, 8'h00, 32'h0, 32'h0, 1'b0);
    fault_present <= 1'b0;
    repeat (10) @(posedge pclk);
    look(3'b010);
    apb(1'b1, 8'h00, 32'h2, 32'h0, 1'b0);
    repeat (10) @(posedge pclk);
    look(3'b100);
    fw_loading <= 1'b1;
    flash(2'b10, 2'b01, 4000);
    fw_loading <= 1'b0;
    fw_done <= 1'b1;
    repeat (10) @(posedge pclk);
    fw_done <= 1'b0;
    fault_present <= 1'b1;
    flash(2'b10, 2'b01, 1000);
    supply_ok <= 1'b0;
    repeat (10) @(posedge pclk);
    look(3'b000);
    apb(1'b0, 8'h08, 32'h0, 32'hB, 1'b0);
    supply_ok <= 1'b1;
    flash(2'b10, 2'b01, 1000);
    fault_present <= 1'b0;
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (400) @(posedge pclk);
    look(3'b100);
    apb(1'b0, 8'h04, 32'h0, 32'h1402, 1'b0);
    final_report;
  end
endmodule // rdl_ready_lamp_tb

`default_nettype wire
